//--- src/ccp_pkg.sv
// Constants and word-length map of the codec control port
package ccp_pkg;
  // ==========================================================
  // How it works
  // - Two-wire after reset; three latch lows switch
  // - Pins change role between two and four wire
  // - First byte: chip address then direction bit
  // - Bytes two, three: subaddress high first; data
  // - Address 01110 plus two strap pin levels
  // - Direction bit one reads, zero writes
  // - Device is slave only, never starts
  // - Start is SDA falling while SCL high
  // - Shift eight bits, acknowledge match, else idle
  // - Stop, SDA rising with SCL high, ends transfer
  // - Start or stop anywhere forces idle or restart
  // - One start, stop or stop-start per high
  // - Invalid subaddress: no acknowledge, go idle
  // - Subaddress advances after each complete word
  // - Word length from subaddress, one to six
  // - Read past end repeats highest register
  // - Write past end: drop byte, no acknowledge
  // - Acknowledge each written byte up to the end on ninth pulse
  // - Read: write subaddress, repeated start, read
  // - Device drives read data; master acknowledges
  // ==========================================================
  localparam logic [4:0] CHIP_FIXED = 5'h0e;
  localparam int SYS_MHZ = 250;
  localparam int SCL_KHZ = 400;
  localparam int SCL_QTR = (SYS_MHZ * 1000) / (SCL_KHZ * 4);
  localparam logic [1:0] LATCH_LOWS = 2'h3;
  localparam logic [2:0] WORD_MAX = 3'h6;
  localparam logic [15:0] PARAM_LO = 16'h0000;
  localparam logic [15:0] PARAM_HI = 16'h03ff;
  localparam logic [15:0] REG_LO = 16'h4000;
  localparam logic [15:0] REG_HI = 16'h40ff;
  localparam logic [15:0] WIDE_REG = 16'h4100;
  localparam logic [2:0] PARAM_LEN = 3'h4;
  localparam logic [2:0] REG_LEN = 3'h1;
  localparam logic [2:0] WIDE_LEN = 3'h6;

  // Zero marks a subaddress that decodes to nothing
  function automatic logic [2:0] ccp_word_len(input logic [15:0] sub);
    if (sub >= PARAM_LO && sub <= PARAM_HI) begin
      return PARAM_LEN;
    end
    if (sub >= REG_LO && sub <= REG_HI) begin
      return REG_LEN;
    end
    if (sub == WIDE_REG) begin
      return WIDE_LEN;
    end
    return 3'h0;
  endfunction : ccp_word_len
endpackage : ccp_pkg

//--- src/ccp_if.sv
// Control port pins shared by the host and the codec device
`timescale 1ns/100ps
interface ccp_if;
  // scl doubles as ctrl_serial_clk, sda as ctrl_serial_out in four-wire mode
  logic scl;
  logic sda;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  // Address bit one in two-wire mode, ctrl_latch_n in four-wire mode
  logic ctrl_latch_n;
  // Address bit zero in two-wire mode, ctrl_serial_in in four-wire mode
  logic addr_sel_lo;
  // Pulled-up open-drain line: low while any enabled driver pulls low
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output scl, output m_sda_o, output m_sda_oe, output ctrl_latch_n,
    output addr_sel_lo, input sda);
  modport device (input scl, input sda, input ctrl_latch_n, input addr_sel_lo,
    output d_sda_o, output d_sda_oe);
endinterface : ccp_if

//--- src/ccp_dev.sv
// Codec control port slave: link engine on LINK_CLK, access port on CLK_SYS
`timescale 1ns/100ps
module ccp_dev (
  input wire logic CLK_SYS,
  input wire logic LINK_CLK,
  input wire logic RSTN,
  ccp_if.device BUS,
  output logic WR_STB,
  output logic RD_STB,
  output logic [15:0] ACC_ADDR,
  output logic [47:0] ACC_WDATA,
  output logic [2:0] ACC_LEN,
  input wire logic [47:0] RD_DATA,
  output logic SPI_MODE
);
  import ccp_pkg::*;

  // ==========================================================
  // Link domain state
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RX = 3'h1,
    D_ACK = 3'h3,
    D_TX = 3'h2,
    D_MACK = 3'h6
  } ccp_dst_t;

  typedef struct packed {
    ccp_dst_t st;
    logic [3:0] bitc;
    logic [1:0] bytn;
    logic [7:0] sh;
    logic rw;
    logic [15:0] sub;
    logic [2:0] wlen;
    logic [2:0] bidx;
    logic end_flag;
    logic [47:0] wbuf;
    logic [47:0] rbuf;
    logic sda_oe;
    logic sda_o;
    logic req_tgl;
    logic req_wr;
    logic [15:0] req_addr;
    logic [2:0] req_len;
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
    logic lat1, lat2, lat3;
    logic alo1, alo2;
    logic rsp1, rsp2, rsp3;
    logic [1:0] lows;
    logic spi;
  } ccp_dlink_t;

  // ==========================================================
  // Core domain state
  typedef struct packed {
    logic rq1, rq2, rq3;
    logic wr_stb;
    logic rd_stb;
    logic [15:0] addr;
    logic [47:0] wdata;
    logic [2:0] len;
    logic [47:0] rdat;
    logic rsp_tgl;
    logic spi1, spi2;
  } ccp_dsys_t;

  ccp_dlink_t r, n;
  ccp_dsys_t s, ns;
  logic scl_rise, scl_fall, start_c, stop_c, adr_match;
  logic [2:0] nlen;

  // ==========================================================
  // Link engine
  // Edges from synchronised samples
  assign scl_rise = r.scl2 & ~r.scl3;
  assign scl_fall = ~r.scl2 & r.scl3;
  assign start_c = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign stop_c = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  assign adr_match = r.sh[7:1] == {CHIP_FIXED, r.lat2, r.alo2};
  assign nlen = ccp_word_len(r.sub + 16'h0001);

  always_comb begin
    n = r;
    n.scl1 = BUS.scl;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = BUS.sda;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    n.lat1 = BUS.ctrl_latch_n;
    n.lat2 = r.lat1;
    n.lat3 = r.lat2;
    n.alo1 = BUS.addr_sel_lo;
    n.alo2 = r.alo1;
    n.rsp1 = s.rsp_tgl;
    n.rsp2 = r.rsp1;
    n.rsp3 = r.rsp2;
    n.sda_o = 1'b0;
    // Count latch lows; only a reset leaves four-wire mode
    if (!r.spi && r.lat3 && !r.lat2) begin
      n.lows = r.lows + 2'h1;
      if (r.lows == LATCH_LOWS - 2'h1) begin
        n.spi = 1'b1;
      end
    end
    // Read word arrives left aligned so bytes leave from the top
    if (r.rsp2 ^ r.rsp3) begin
      n.rbuf = s.rdat << {WORD_MAX - r.wlen, 3'h0};
    end
    if (r.spi) begin
      // Four-wire pins: serial output stays released here
      n.st = D_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.st = D_RX;
      n.bitc = 4'h0;
      n.bytn = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = D_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        D_IDLE: begin
          n.sda_oe = 1'b0;
        end
        D_RX: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], r.sda2};
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fall && r.bitc == 4'h8) begin
            n.st = D_ACK;
            n.sda_oe = 1'b1;
            n.bytn = (r.bytn == 2'h3) ? r.bytn : r.bytn + 2'h1;
            unique case (r.bytn)
              2'h0: begin
                // Address byte; direction in bit zero
                n.rw = r.sh[0];
                n.bidx = 3'h0;
                if (!adr_match || (r.sh[0] && r.wlen == 3'h0)) begin
                  n.st = D_IDLE;
                  n.sda_oe = 1'b0;
                end else if (r.sh[0]) begin
                  // Fetch the first word for the master
                  n.req_addr = r.sub;
                  n.req_len = r.wlen;
                  n.req_wr = 1'b0;
                  n.req_tgl = ~r.req_tgl;
                end
              end
              2'h1: begin
                n.sub[15:8] = r.sh;
              end
              2'h2: begin
                if (ccp_word_len({r.sub[15:8], r.sh}) == 3'h0) begin
                  n.st = D_IDLE;
                  n.sda_oe = 1'b0;
                end else begin
                  // Low byte; look up word length
                  n.sub[7:0] = r.sh;
                  n.wlen = ccp_word_len({r.sub[15:8], r.sh});
                  n.bidx = 3'h0;
                  n.end_flag = 1'b0;
                end
              end
              default: begin
                if (r.end_flag) begin
                  // Past the end: discard, no acknowledge
                  n.st = D_IDLE;
                  n.sda_oe = 1'b0;
                end else begin
                  n.wbuf = (r.bidx == 3'h0) ? {40'h0000_0000_00, r.sh} : {r.wbuf[39:0], r.sh};
                  n.bidx = r.bidx + 3'h1;
                  if (r.bidx + 3'h1 == r.wlen) begin
                    n.bidx = 3'h0;
                    n.req_addr = r.sub;
                    n.req_len = r.wlen;
                    n.req_wr = 1'b1;
                    n.req_tgl = ~r.req_tgl;
                    if (nlen == 3'h0) begin
                      n.end_flag = 1'b1;
                    end else begin
                      n.sub = r.sub + 16'h0001;
                      n.wlen = nlen;
                    end
                  end
                end
              end
            endcase
          end
        end
        D_ACK: begin
          // Hold through the ninth pulse, then hand the line on
          if (scl_fall) begin
            n.bitc = 4'h0;
            n.st = r.rw ? D_TX : D_RX;
            // Device drives data on the read side
            n.sda_oe = r.rw & ~r.rbuf[47];
          end
        end
        D_TX: begin
          if (scl_rise) begin
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fall) begin
            if (r.bitc == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st = D_MACK;
            end else begin
              n.sda_oe = ~r.rbuf[6'd47 - {2'h0, r.bitc}];
            end
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            if (r.sda2) begin
              n.st = D_IDLE;
            end else begin
              n.st = D_ACK;
              n.rbuf = r.rbuf << 8;
              n.bidx = r.bidx + 3'h1;
              if (r.bidx + 3'h1 == r.wlen) begin
                n.bidx = 3'h0;
                n.req_wr = 1'b0;
                n.req_len = r.wlen;
                n.req_tgl = ~r.req_tgl;
                n.req_addr = r.sub;
                // At the end keep rereading the last word
                if (nlen == 3'h0) begin
                  n.end_flag = 1'b1;
                end else begin
                  n.sub = r.sub + 16'h0001;
                  n.wlen = nlen;
                  n.req_addr = r.sub + 16'h0001;
                  n.req_len = nlen;
                end
              end
            end
          end
        end
        default: begin
          n.st = D_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Core side: toggle handshake to the access port
  always_comb begin
    ns = s;
    ns.rq1 = r.req_tgl;
    ns.rq2 = s.rq1;
    ns.rq3 = s.rq2;
    ns.spi1 = r.spi;
    ns.spi2 = s.spi1;
    ns.wr_stb = 1'b0;
    ns.rd_stb = 1'b0;
    // Payload is held steady for many bus bits after each toggle
    if (s.rq2 ^ s.rq3) begin
      ns.addr = r.req_addr;
      ns.len = r.req_len;
      ns.wdata = r.wbuf;
      ns.wr_stb = r.req_wr;
      ns.rd_stb = ~r.req_wr;
    end
    if (s.rd_stb) begin
      ns.rdat = RD_DATA;
      ns.rsp_tgl = ~s.rsp_tgl;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s <= '0;
    end else begin
      s <= ns;
    end
  end

  assign BUS.d_sda_oe = r.sda_oe;
  assign BUS.d_sda_o = r.sda_o;
  assign WR_STB = s.wr_stb;
  assign RD_STB = s.rd_stb;
  assign ACC_ADDR = s.addr;
  assign ACC_WDATA = s.wdata;
  assign ACC_LEN = s.len;
  assign SPI_MODE = s.spi2;
endmodule : ccp_dev

//--- src/ccp_host.sv
// Bus master for the codec control port, SCL divided from CLK_SYS
`timescale 1ns/100ps
module ccp_host #(
  parameter int QTR = ccp_pkg::SCL_QTR
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  ccp_if.host BUS,
  input wire logic CMD_GO,
  input wire logic CMD_RD,
  input wire logic CMD_SPI,
  input wire logic [15:0] CMD_SUB,
  input wire logic [2:0] CMD_LEN,
  input wire logic [47:0] CMD_WDATA,
  input wire logic STRAP_HI,
  input wire logic STRAP_LO,
  output logic BUSY,
  output logic DONE,
  output logic NACK,
  output logic [47:0] RD_DATA
);
  import ccp_pkg::*;

  if (QTR < 8 || QTR > 65535) begin : g_chk
    $error("QTR out of range");
  end

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_BITS = 3'h3,
    M_STOP = 3'h2,
    M_RSTART = 3'h6,
    M_LATCH = 3'h4
  } ccp_mst_t;

  typedef struct packed {
    ccp_mst_t st;
    logic [15:0] div;
    logic [1:0] q;
    logic [3:0] bitc;
    logic [2:0] bytn;
    logic rd;
    logic [15:0] sub;
    logic [2:0] left;
    logic [47:0] wbuf;
    logic [47:0] rbuf;
    logic [7:0] tx;
    logic [7:0] rx;
    logic nak;
    logic scl, sda_oe, lat, alo, hi;
    logic sda1, sda2;
    logic busy, done, nack;
  } ccp_mhost_t;

  localparam ccp_mhost_t M_RST = '{st: M_IDLE, scl: 1'b1, lat: 1'b1, default: '0};
  ccp_mhost_t r, n;
  logic tick, recv;
  logic [7:0] adr_w;

  assign tick = r.div == 16'(QTR - 1);
  // Address byte with bit zero clear; it is ORed in when sent for reads
  assign adr_w = {CHIP_FIXED, r.hi, r.alo, 1'b0};
  assign recv = r.rd & (r.bytn == 3'h4);

  always_comb begin
    n = r;
    n.sda1 = BUS.sda;
    n.sda2 = r.sda1;
    n.done = 1'b0;
    n.div = tick ? 16'h0000 : r.div + 16'h0001;
    if (tick && r.st != M_IDLE) begin
      n.q = r.q + 2'h1;
    end
    unique case (r.st)
      M_IDLE: begin
        n.div = 16'h0000;
        n.q = 2'h0;
        n.hi = STRAP_HI;
        n.alo = STRAP_LO;
        n.lat = STRAP_HI;
        if (CMD_SPI) begin
          n.st = M_LATCH;
          n.busy = 1'b1;
          n.bitc = 4'h0;
        end else if (CMD_GO) begin
          n.st = M_START;
          n.busy = 1'b1;
          n.nack = 1'b0;
          n.rd = CMD_RD;
          n.sub = CMD_SUB;
          n.left = CMD_LEN;
          n.wbuf = CMD_WDATA << {WORD_MAX - CMD_LEN, 3'h0};
          n.bytn = 3'h0;
          n.bitc = 4'h0;
          n.tx = {CHIP_FIXED, STRAP_HI, STRAP_LO, 1'b0};
        end
      end
      M_LATCH: begin
        // Three low pulses on the latch pin
        if (tick) begin
          n.lat = r.bitc[0];
          n.bitc = r.bitc + 4'h1;
          if (r.bitc == 4'h6) begin
            n.lat = r.hi;
            n.st = M_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
          end
        end
      end
      M_START: begin
        // SDA falls while SCL is high
        if (tick) begin
          unique case (r.q)
            2'h0: n.scl = 1'b1;
            2'h1: n.sda_oe = 1'b1;
            2'h2: n.sda_oe = 1'b1;
            2'h3: begin
              n.scl = 1'b0;
              n.st = M_BITS;
            end
          endcase
        end
      end
      M_RSTART: begin
        // Repeated start before the read address
        if (tick) begin
          unique case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe = 1'b1;
            2'h3: begin
              n.scl = 1'b0;
              n.st = M_BITS;
            end
          endcase
        end
      end
      M_STOP: begin
        // SDA rises while SCL is high
        if (tick) begin
          unique case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe = 1'b0;
            2'h3: begin
              n.st = M_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
      end
      M_BITS: begin
        if (tick) begin
          unique case (r.q)
            2'h0: begin
              if (r.bitc == 4'h8) begin
                // Acknowledge all but the last read byte
                n.sda_oe = recv & (r.left != 3'h1);
              end else begin
                n.sda_oe = ~recv & ~r.tx[3'h7 - r.bitc[2:0]];
              end
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitc == 4'h8) begin
                n.nak = r.sda2;
              end else begin
                n.rx = {r.rx[6:0], r.sda2};
              end
            end
            2'h3: begin
              n.scl = 1'b0;
              n.bitc = r.bitc + 4'h1;
              if (r.bitc == 4'h8) begin
                n.bitc = 4'h0;
                if (recv) begin
                  n.rbuf = {r.rbuf[39:0], r.rx};
                  n.left = r.left - 3'h1;
                  n.st = (r.left == 3'h1) ? M_STOP : M_BITS;
                end else if (r.nak) begin
                  n.nack = 1'b1;
                  n.st = M_STOP;
                end else if (r.bytn == 3'h0) begin
                  n.bytn = 3'h1;
                  n.tx = r.sub[15:8];
                end else if (r.bytn == 3'h1) begin
                  n.bytn = 3'h2;
                  n.tx = r.sub[7:0];
                end else if (r.bytn == 3'h2 && r.rd) begin
                  n.bytn = 3'h3;
                  n.tx = adr_w | 8'h01;
                  n.st = M_RSTART;
                end else if (r.bytn == 3'h2) begin
                  n.bytn = 3'h3;
                  n.tx = r.wbuf[47:40];
                end else if (r.rd) begin
                  n.bytn = 3'h4;
                  n.rbuf = 48'h0000_0000_0000;
                end else if (r.left == 3'h1) begin
                  n.st = M_STOP;
                end else begin
                  n.left = r.left - 3'h1;
                  n.wbuf = r.wbuf << 8;
                  n.tx = r.wbuf[39:32];
                end
              end
            end
          endcase
        end
      end
      default: n.st = M_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      r <= M_RST;
    end else begin
      r <= n;
    end
  end

  assign BUS.scl = r.scl;
  assign BUS.m_sda_oe = r.sda_oe;
  assign BUS.m_sda_o = 1'b0;
  assign BUS.ctrl_latch_n = r.lat;
  assign BUS.addr_sel_lo = r.alo;
  assign BUSY = r.busy;
  assign DONE = r.done;
  assign NACK = r.nack;
  assign RD_DATA = r.rbuf;
endmodule : ccp_host

//--- testbench/ccp_props.sv
// Concurrent checks on the control port wires
`timescale 1ns/100ps
module ccp_props (
  input wire logic LINK_CLK,
  input wire logic RSTN,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe
);
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (!RSTN);
  // ==========================================================
  // Bus condition helpers
  logic scl_q;
  logic sda_q;
  logic [7:0] nrise;
  // Rises of SCL since the last start, saturating so long bursts never wrap
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nrise <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (sda_q && !sda && scl && scl_q) begin
        nrise <= 8'h00;
      end else if (scl && !scl_q && nrise != 8'hff) begin
        nrise <= nrise + 8'h01;
      end
    end
  end
  sequence start_seen;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence stop_seen;
    $rose(sda) && scl && $past(scl);
  endsequence
  // ==========================================================
  // Assertions
  chk_dev_pull_only: assert property (d_sda_oe |-> !d_sda_o)
    else $error("device drove sda high");
  chk_host_pull_only: assert property (m_sda_oe |-> !m_sda_o)
    else $error("host drove sda high");
  chk_dev_edge_low: assert property ((d_sda_oe != $past(d_sda_oe)) |-> !scl)
    else $error("device changed sda while scl high");
  chk_dev_no_start: assert property (start_seen |-> !d_sda_oe)
    else $error("start made by device");
  chk_ack_hold: assert property ($rose(d_sda_oe) |=> d_sda_oe [*8])
    else $error("device pull too short");
  chk_addr_by_host: assert property (scl && !scl_q && nrise < 8'h08 |-> !d_sda_oe)
    else $error("device drove during address bits");
  chk_start_quiet: assert property (start_seen |=> !d_sda_oe [*8])
    else $error("device drove right after start");
  chk_one_cond: assert property (start_seen |=> !($rose(sda) && scl && $past(scl)) [*8])
    else $error("stop in same high as start");
  cov_dev_ack: cover property ($rose(d_sda_oe));
endmodule : ccp_props

//--- testbench/tb_codec_control_port_i2c_slave.sv
// Self-checking bench: host and device joined across the control port
`timescale 1ns/100ps
module tb_codec_control_port_i2c_slave;
  import ccp_pkg::*;
  logic clk_sys, link_clk, rstn;
  logic cmd_go, cmd_rd, cmd_spi, busy, done, nack;
  logic [15:0] cmd_sub;
  logic [2:0] cmd_len;
  logic [47:0] cmd_wdata, h_rd, dev_rd;
  logic wr_stb, rd_stb, spi_mode;
  logic [15:0] acc_addr, s_addr;
  logic [47:0] acc_wdata, s_data;
  logic [2:0] acc_len, s_len;
  int num_errors = 0;
  int compares = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int base;
  int rbase;
  logic strap_lo;
  ccp_if bus();
  ccp_host #(.QTR(8)) u_ccp_host (.CLK_SYS(clk_sys), .RSTN(rstn), .BUS(bus), .CMD_GO(cmd_go),
    .CMD_RD(cmd_rd), .CMD_SPI(cmd_spi), .CMD_SUB(cmd_sub), .CMD_LEN(cmd_len), .CMD_WDATA(cmd_wdata),
    .STRAP_HI(1'b1), .STRAP_LO(strap_lo), .BUSY(busy), .DONE(done), .NACK(nack), .RD_DATA(h_rd));
  ccp_dev u_ccp_dev (.CLK_SYS(clk_sys), .LINK_CLK(link_clk), .RSTN(rstn), .BUS(bus), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata), .ACC_LEN(acc_len), .RD_DATA(dev_rd),
    .SPI_MODE(spi_mode));
  ccp_props u_ccp_props (.LINK_CLK(link_clk), .RSTN(rstn), .scl(bus.scl), .sda(bus.sda),
    .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe), .d_sda_o(bus.d_sda_o), .d_sda_oe(bus.d_sda_oe));
  // ==========================================================
  // Clocks, access side model, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Read word is a plain function of the subaddress in every byte pair, so repeats are visible
  always @(negedge clk_sys) begin
    dev_rd <= {acc_addr ^ 16'h5a5a, acc_addr ^ 16'h5a5a, acc_addr ^ 16'h5a5a};
    if (rd_stb === 1'b1) begin
      rd_cnt++;
    end
    if (wr_stb === 1'b1) begin
      wr_cnt++;
      s_addr = acc_addr;
      s_data = acc_wdata;
      s_len = acc_len;
    end
  end
  initial begin
    #200_000;
    num_errors++;
    complete_run();
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic run(input logic spi, input logic rd, input logic [15:0] sub, input logic [2:0] len,
    input logic [47:0] data);
    int n;
    base = wr_cnt;
    rbase = rd_cnt;
    @(negedge clk_sys);
    {cmd_spi, cmd_go, cmd_rd, cmd_sub, cmd_len, cmd_wdata} = {spi, ~spi, rd, sub, len, data};
    @(negedge clk_sys);
    {cmd_spi, cmd_go} = 2'h0;
    check("busy", {47'h0, busy}, 48'h1);
    for (n = 0; n < 20000 && done !== 1'b1; n++) @(negedge clk_sys);
    check("done", {47'h0, done}, 48'h1);
    check("idle", {47'h0, busy}, 48'h0);
    repeat (40) @(negedge clk_sys);
  endtask : run
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Scenarios
  // Single byte write
  task automatic t_write_one();
    check("mode", {47'h0, spi_mode}, 48'h0);
    run(1'b0, 1'b0, 16'h4005, 3'h1, 48'h0000_0000_00a5);
    check("nack", {47'h0, nack}, 48'h0);
    check("strobes", 48'(wr_cnt - base), 48'h1);
    check("addr", {32'h0, s_addr}, 48'h0000_0000_4005);
    check("wdata", s_data, 48'h0000_0000_00a5);
  endtask : t_write_one
  task automatic t_write_wide();
    run(1'b0, 1'b0, WIDE_REG, 3'h6, 48'h1122_3344_5566);
    check("strobes", 48'(wr_cnt - base), 48'h1);
    check("len", {45'h0, s_len}, 48'h6);
    check("wdata", s_data, 48'h1122_3344_5566);
  endtask : t_write_wide
  task automatic t_burst();
    // Other strap level moves the chip address to the next slot
    strap_lo = 1'b1;
    run(1'b0, 1'b0, 16'h4010, 3'h3, 48'h0000_000a_0b0c);
    strap_lo = 1'b0;
    check("strobes", 48'(wr_cnt - base), 48'h3);
    check("addr", {32'h0, s_addr}, 48'h0000_0000_4012);
    check("wdata", s_data, 48'h0000_0000_000c);
  endtask : t_burst
  // Write past the end: last parameter word, then one byte too many
  task automatic t_write_end();
    run(1'b0, 1'b0, PARAM_HI, 3'h5, 48'h0011_2233_4455);
    check("strobes", 48'(wr_cnt - base), 48'h1);
    check("wdata", s_data, 48'h0000_1122_3344);
    check("nack", {47'h0, nack}, 48'h1);
  endtask : t_write_end
  task automatic t_bad_sub();
    run(1'b0, 1'b0, 16'h2000, 3'h1, 48'h0000_0000_0033);
    check("strobes", 48'(wr_cnt - base), 48'h0);
    check("nack", {47'h0, nack}, 48'h1);
  endtask : t_bad_sub
  // Reads, plain and past the end
  task automatic t_reads();
    run(1'b0, 1'b1, 16'h4001, 3'h2, 48'h0);
    check("nack", {47'h0, nack}, 48'h0);
    check("rdata", {32'h0, h_rd[15:0]}, 48'h0000_0000_5b58);
    check("rd strobes", 48'(rd_cnt - rbase), 48'h2);
    run(1'b0, 1'b1, PARAM_HI, 3'h6, 48'h0);
    check("rdata", h_rd, 48'h59a5_59a5_59a5);
    check("rd strobes", 48'(rd_cnt - rbase), 48'h2);
  endtask : t_reads
  // Switch to four-wire, then no answer
  task automatic t_spi();
    int n;
    run(1'b1, 1'b0, 16'h0, 3'h1, 48'h0);
    for (n = 0; n < 200 && spi_mode !== 1'b1; n++) @(negedge clk_sys);
    check("mode", {47'h0, spi_mode}, 48'h1);
    run(1'b0, 1'b0, 16'h4005, 3'h1, 48'h0000_0000_0011);
    check("nack", {47'h0, nack}, 48'h1);
    check("strobes", 48'(wr_cnt - base), 48'h0);
  endtask : t_spi
  initial begin
    rstn = 1'b0;
    {cmd_go, cmd_rd, cmd_spi, cmd_sub, cmd_len, cmd_wdata} = '0;
    strap_lo = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (8) @(negedge clk_sys);
    t_write_one();
    t_write_wide();
    t_burst();
    t_write_end();
    t_bad_sub();
    t_reads();
    t_spi();
    complete_run();
  end
endmodule : tb_codec_control_port_i2c_slave
